// [src/uds_pkg.sv]
package uds_pkg;

  // Receive FIFO geometry
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_AW = 4;
  localparam int unsigned CNT_W = 5;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] CNT_EMPTY = 5'h00;

  // Register byte offsets
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_LINE_CTRL = 12'h008;
  localparam logic [11:0] OFS_RAW_INT = 12'h00c;
  localparam logic [11:0] OFS_INT_MASK = 12'h010;
  localparam logic [11:0] OFS_FIFO_LEVEL = 12'h014;

  // Flag positions in the data register
  localparam int unsigned DR_FE_BIT = 8;
  localparam int unsigned DR_PE_BIT = 9;
  localparam int unsigned DR_BE_BIT = 10;
  localparam int unsigned DR_OE_BIT = 11;

  // Flag positions in the receive status register
  localparam int unsigned RS_FE_BIT = 0;
  localparam int unsigned RS_PE_BIT = 1;
  localparam int unsigned RS_BE_BIT = 2;
  localparam int unsigned RS_OE_BIT = 3;

  // Line control bits used here
  localparam int unsigned LC_PEN_BIT = 1;
  localparam int unsigned LC_EPS_BIT = 2;
  localparam int unsigned LC_FEN_BIT = 4;
  localparam int unsigned LC_SPS_BIT = 7;
  localparam logic [7:0] LC_RESET = 8'h00;

  // Interrupt bits, shared by raw status and mask
  localparam int unsigned INT_RX = 0;
  localparam int unsigned INT_OE = 1;
  localparam int unsigned INT_BE = 2;
  localparam int unsigned INT_PE = 3;
  localparam int unsigned INT_FE = 4;
  localparam int unsigned INT_W = 5;
  localparam logic [4:0] INT_RESET = 5'h00;

  localparam logic [3:0] RS_RESET = 4'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [7:0] CHAR_ZERO = 8'h00;

  // Character as delivered by the receive shifter
  typedef struct packed {
    logic stop_bit;   // Sampled stop bit
    logic parity_bit; // Sampled parity bit
    logic [7:0] data; // Data bits
  } uds_rx_char_t;

  // FIFO entry, upper bits ordered as in the data register
  typedef struct packed {
    logic brk;        // Break
    logic par_err;    // Parity error
    logic frm_err;    // Framing error
    logic [7:0] data; // Character
  } uds_rx_entry_t;

  // Receive acceptance state
  typedef enum logic {
    RX_RUN = 1'b0,
    RX_WAIT_IDLE = 1'b1
  } uds_rx_state_t;

endpackage

// [src/uds_rxmem.sv]
`timescale 1ns/10ps
module uds_rxmem
  import uds_pkg::*;
(
  input wire logic clk,                          // Clock
  input wire logic ce,                           // Clock enable
  input wire logic we,                           // Write strobe
  input wire logic [uds_pkg::FIFO_AW-1:0] waddr, // Write address
  input uds_pkg::uds_rx_entry_t wdata,           // Write data
  input wire logic [uds_pkg::FIFO_AW-1:0] raddr, // Read address
  output uds_pkg::uds_rx_entry_t rdata           // Registered read data
);

  uds_rx_entry_t mem [FIFO_DEPTH]; // Entry storage

  // Write port
  always_ff @(posedge clk)
  begin
    if (ce && we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Read port, registered so the head settles one cycle after a pointer move
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      rdata <= mem[raddr];
    end
  end

endmodule

// [src/uds_top.sv]
`timescale 1ns/10ps
module uds_top
  import uds_pkg::*;
(
  input wire logic MCLK,                   // System clock, 100 MHz
  input wire logic SRST,                   // Synchronous reset, high
  input wire logic CE,                     // Clock enable, freezes all state
  input wire logic HSEL,                   // Slave select
  input wire logic [31:0] HADDR,           // Byte address
  input wire logic [1:0] HTRANS,           // Transfer type
  input wire logic HWRITE,                 // Write when high
  input wire logic [2:0] HSIZE,            // Word only
  input wire logic HREADY,                 // Bus ready
  input wire logic [31:0] HWDATA,          // Write data
  output logic [31:0] HRDATA,              // Read data
  output logic HREADYOUT,                  // Slave ready
  output logic HRESP,                      // Always OKAY
  input wire logic RX_VALID,               // Character from shifter, pulse
  input uds_pkg::uds_rx_char_t RX_CHAR,    // Received character
  input wire logic RX_LINE,                // Receive line level
  output logic TX_VALID,                   // Character to transmit, pulse
  output logic [7:0] TX_DATA,              // Character to transmit
  output logic IRQ                         // Interrupt level
);

  ////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic wr_pend;              // Write data phase pending
  logic rd_pend;              // Read data phase pending
  logic [11:0] ph_addr;       // Captured offset
  logic addr_take;            // Address phase accepted
  logic wr_do;                // Write data taken this cycle
  logic rd_do;                // Read answer loaded this cycle

  assign addr_take = HSEL && HTRANS[1] && HREADY;
  assign wr_do = CE && wr_pend;
  assign rd_do = CE && rd_pend;

  // Address phase capture; reads cost one wait state
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ph_addr <= OFS_DATA;
      HREADYOUT <= 1'b1;
    end
    else if (CE)
    begin
      wr_pend <= addr_take && HWRITE;
      rd_pend <= addr_take && !HWRITE;
      if (addr_take)
      begin
        ph_addr <= HADDR[11:0];
      end
      // Low while a read answer is being fetched
      HREADYOUT <= !(addr_take && !HWRITE);
    end
  end

  // Errors are never signalled
  always_ff @(posedge MCLK)
  begin
    HRESP <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [7:0] line_control_reg; // Parity and FIFO settings
  logic [INT_W-1:0] int_mask;   // Interrupt mask
  logic wr_dr;                  // Data register write
  logic wr_ecr;                 // Error-clear write

  assign wr_dr = wr_do && (ph_addr == OFS_DATA);
  assign wr_ecr = wr_do && (ph_addr == OFS_STATUS);

  // Line control and mask, written by software
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      line_control_reg <= LC_RESET;
      int_mask <= INT_RESET;
    end
    else if (wr_do && ph_addr == OFS_LINE_CTRL)
    begin
      line_control_reg <= HWDATA[7:0];
    end
    else if (wr_do && ph_addr == OFS_INT_MASK)
    begin
      int_mask <= HWDATA[INT_W-1:0];
    end
  end

  // Transmit handoff, one pulse per write
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      TX_VALID <= 1'b0;
      TX_DATA <= CHAR_ZERO;
    end
    else if (CE)
    begin
      TX_VALID <= wr_dr;
      if (wr_dr)
      begin
        TX_DATA <= HWDATA[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive check and break handling

  uds_rx_state_t rx_state;  // Acceptance state
  logic rx_take;            // Character accepted
  logic par_expect;         // Parity bit the settings call for
  logic is_break;           // Whole frame low
  uds_rx_entry_t next_entry; // Entry to store

  assign rx_take = CE && RX_VALID && (rx_state == RX_RUN);
  // Stick parity forces the bit; otherwise even or odd over the data
  assign par_expect = line_control_reg[LC_SPS_BIT] ? !line_control_reg[LC_EPS_BIT]
                    : (line_control_reg[LC_EPS_BIT] ? ^RX_CHAR.data : !(^RX_CHAR.data));
  assign is_break = (RX_CHAR.data == CHAR_ZERO) && !RX_CHAR.stop_bit
                    && !(line_control_reg[LC_PEN_BIT] && RX_CHAR.parity_bit);

  always_comb
  begin
    next_entry.data = RX_CHAR.data;
    next_entry.brk = is_break;
    next_entry.frm_err = !RX_CHAR.stop_bit && !is_break;
    next_entry.par_err = line_control_reg[LC_PEN_BIT] && !is_break
                         && (RX_CHAR.parity_bit != par_expect);
    if (is_break)
    begin
      next_entry.data = CHAR_ZERO;
    end
  end

  // After a break, ignore the line until it idles high again
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      rx_state <= RX_RUN;
    end
    else if (CE)
    begin
      case (rx_state)
        RX_RUN:
        begin
          if (RX_VALID && is_break)
          begin
            rx_state <= RX_WAIT_IDLE;
          end
        end
        RX_WAIT_IDLE:
        begin
          if (RX_LINE)
          begin
            rx_state <= RX_RUN;
          end
        end
        default:
        begin
          rx_state <= RX_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive FIFO

  logic [FIFO_AW-1:0] wr_ptr;   // Next write slot
  logic [FIFO_AW-1:0] rd_ptr;   // Head slot
  logic [CNT_W-1:0] count;      // Entries held
  logic [CNT_W-1:0] count_seen; // Count aligned with registered head
  logic full;                   // No room
  logic push;                   // Entry stored
  logic pop;                    // Head consumed by a data read
  uds_rx_entry_t head;          // Head entry, registered

  // Without FIFO mode the store behaves as a single holding register
  assign full = line_control_reg[LC_FEN_BIT] ? (count == CNT_FULL) : (count != CNT_EMPTY);
  assign push = rx_take && !full;
  assign pop = rd_do && (ph_addr == OFS_DATA) && (count_seen != CNT_EMPTY);

  uds_rxmem u_mem (
    .clk(MCLK),
    .ce(CE),
    .we(push),
    .waddr(wr_ptr),
    .wdata(next_entry),
    .raddr(rd_ptr),
    .rdata(head)
  );

  // Pointers and fill level
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= CNT_EMPTY;
      count_seen <= CNT_EMPTY;
    end
    else if (CE)
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + CNT_ONE;
      end
      else if (pop && !push)
      begin
        count <= count - CNT_ONE;
      end
      // Lags a cycle so a read never sees a slot before its data
      count_seen <= count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error status and interrupts

  logic [3:0] rx_status;        // Receive status flags
  logic [INT_W-1:0] raw_int;    // Sticky events
  logic [INT_W-1:0] int_set;    // Events this cycle
  logic overrun;                // Character lost

  assign overrun = rx_take && full;
  assign int_set = {rx_take && next_entry.frm_err, rx_take && next_entry.par_err,
                    rx_take && next_entry.brk, overrun, push};

  // Flags follow the entry last read; overrun is raised on the spot
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      rx_status <= RS_RESET;
    end
    else if (CE)
    begin
      if (wr_ecr)
      begin
        rx_status <= RS_RESET;
      end
      if (pop)
      begin
        rx_status[RS_FE_BIT] <= head.frm_err;
        rx_status[RS_PE_BIT] <= head.par_err;
        rx_status[RS_BE_BIT] <= head.brk;
      end
      if (overrun)
      begin
        rx_status[RS_OE_BIT] <= 1'b1;
      end
    end
  end

  // Raw status, write one to clear; a new event beats the clear
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      raw_int <= INT_RESET;
    end
    else if (CE)
    begin
      if (wr_do && ph_addr == OFS_RAW_INT)
      begin
        raw_int <= (raw_int & ~HWDATA[INT_W-1:0]) | int_set;
      end
      else
      begin
        raw_int <= raw_int | int_set;
      end
    end
  end

  // Interrupt level from a flop
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      IRQ <= 1'b0;
    end
    else if (CE)
    begin
      IRQ <= |(raw_int & int_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read answer

  // Loaded in the wait cycle; unmapped offsets read zero
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      HRDATA <= WORD_ZERO;
    end
    else if (rd_do)
    begin
      HRDATA <= WORD_ZERO;
      case (ph_addr)
        OFS_DATA:
        begin
          if (count_seen != CNT_EMPTY)
          begin
            HRDATA[10:0] <= head;
          end
          HRDATA[DR_OE_BIT] <= rx_status[RS_OE_BIT];
        end
        OFS_STATUS: HRDATA[3:0] <= rx_status;
        OFS_LINE_CTRL: HRDATA[7:0] <= line_control_reg;
        OFS_RAW_INT: HRDATA[INT_W-1:0] <= raw_int;
        OFS_INT_MASK: HRDATA[INT_W-1:0] <= int_mask;
        OFS_FIFO_LEVEL: HRDATA[CNT_W-1:0] <= count;
        default: HRDATA <= WORD_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_parity_flag: assert property (@(posedge MCLK) disable iff (SRST)
    (rx_take && line_control_reg[LC_PEN_BIT] && !is_break && RX_CHAR.parity_bit != par_expect)
    |=> raw_int[INT_PE])
    else $error("parity mismatch did not raise its flag");

  a_head_flags_read: assert property (@(posedge MCLK) disable iff (SRST)
    pop |=> (HRDATA[DR_BE_BIT:DR_FE_BIT] == {$past(head.brk), $past(head.par_err), $past(head.frm_err)}))
    else $error("read flags do not belong to head character");

  a_framing_flag: assert property (@(posedge MCLK) disable iff (SRST)
    (rx_take && !RX_CHAR.stop_bit && !is_break) |=> raw_int[INT_FE])
    else $error("low stop bit did not raise framing flag");

  a_tx_pass: assert property (@(posedge MCLK) disable iff (SRST)
    wr_dr |=> (TX_VALID && TX_DATA == $past(HWDATA[7:0])))
    else $error("written byte not handed to transmitter");

  a_rx_data_read: assert property (@(posedge MCLK) disable iff (SRST)
    pop |=> (HRDATA[7:0] == $past(head.data) && HREADYOUT))
    else $error("read data is not the head character");

  a_overrun_now: assert property (@(posedge MCLK) disable iff (SRST)
    (CE && RX_VALID && rx_state == RX_RUN && full)
    |=> (rx_status[RS_OE_BIT] && count == ($past(count) - ($past(pop) ? CNT_ONE : CNT_EMPTY))))
    else $error("overrun not flagged at once");

  a_error_clear: assert property (@(posedge MCLK) disable iff (SRST)
    (wr_ecr && !overrun && !pop) |=> (rx_status == RS_RESET))
    else $error("error clear left a flag set");

  a_break_single: assert property (@(posedge MCLK) disable iff (SRST)
    (rx_take && is_break) |=> (rx_state == RX_WAIT_IDLE && !push))
    else $error("break did not hold off the next character");

  // The line may return high at any time after a break, so only the hold state is checked
  a_break_hold: assert property (@(posedge MCLK) disable iff (SRST)
    (rx_state == RX_WAIT_IDLE) |-> !push)
    else $error("character stored while waiting for idle line");

endmodule

// [testbench/uds_line_peer.sv]
`timescale 1ns/10ps
module uds_line_peer
  import uds_pkg::*;
(
  input wire logic clk,                   // System clock
  output logic rx_valid,                  // Character strobe
  output uds_pkg::uds_rx_char_t rx_char,  // Character with parity and stop
  output logic rx_line,                   // Line level, high idle
  input wire logic tx_valid,              // Transmit strobe
  input wire logic [7:0] tx_data          // Transmit byte
);
  import uds_pkg::*;
  logic [7:0] tx_last = 8'h00; // Last byte handed to us
  int tx_count = 0; // Bytes handed to us

  initial
  begin
    rx_valid = 1'b0;
    rx_char = '0;
    rx_line = 1'b1;
  end

  ////////////////////////////////////////////////////////////
  // Collect transmitted bytes
  always @(posedge clk)
  begin
    if (tx_valid === 1'b1)
    begin
      tx_last <= tx_data;
      tx_count <= tx_count + 1;
    end
  end

  // One character; the bus shows garbage once the strobe drops
  task send(input logic [7:0] d, input logic par, input logic stp);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char <= {stp, par, d};
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char <= ~{stp, par, d};
    repeat (2) @(posedge clk);
  endtask

  // Line held low models a break, high ends it
  task hold_line(input logic v);
    @(posedge clk);
    rx_line <= v;
  endtask
endmodule

// [testbench/uds_top_tb.sv]
`timescale 1ns/10ps
module uds_top_tb;
  import uds_pkg::*;
  logic mclk, srst, hsel, hwrite, hreadyout, hresp, irq, tx_valid, rx_valid, rx_line, p;
  logic ce; // Clock enable to the design
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [7:0] tx_data, d;
  uds_rx_char_t rx_char;
  int bad_count = 0;
  int n_compared = 0;

  uds_top dut_u (.MCLK(mclk), .SRST(srst), .CE(ce), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .RX_VALID(rx_valid), .RX_CHAR(rx_char), .RX_LINE(rx_line),
    .TX_VALID(tx_valid), .TX_DATA(tx_data), .IRQ(irq));

  uds_line_peer peer_u (.clk(mclk), .rx_valid(rx_valid), .rx_char(rx_char), .rx_line(rx_line),
    .tx_valid(tx_valid), .tx_data(tx_data));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////
  // Verdict and stop
  task end_of_test;
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for hready; a hang ends the run
  task wait_rdy;
    int i;
    for (i = 0; i < 50; i++)
    begin
      @(posedge mclk);
      if (hreadyout === 1'b1)
        return;
    end
    bad_count++;
    end_of_test();
  endtask

  // One single word transfer, address phase then data phase
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h00000, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    q = hrdata;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, rd);
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    // Flags clear out of reset
    rdc(OFS_DATA, 32'h0000_0000);
    rdc(OFS_STATUS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    // Upper bits of a write must not leak to the line
    wr(OFS_DATA, 32'h0000_01a5);
    repeat (2) @(posedge mclk);
    chk({24'h0, peer_u.tx_last}, 32'h0000_00a5);
    chk(peer_u.tx_count, 32'h0000_0001);
    // Each enabled parity mode (odd, even, both stick): good, bad parity, bad stop, queued together
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_LINE_CTRL, {24'h0, m[1], 4'h2, m[0], 2'h2});
      d = 8'h35 + m[7:0];
      p = m[1] ? ~m[0] : (m[0] ? ^d : ~^d);
      peer_u.send(d, p, 1'b1);
      peer_u.send(d, ~p, 1'b1);
      peer_u.send(d, p, 1'b0);
      rdc(OFS_DATA, {24'h0, d});
      rdc(OFS_DATA, 32'h200 | d);
      rdc(OFS_DATA, 32'h100 | d);
    end
    // Overrun: one character beyond a full FIFO
    wr(OFS_LINE_CTRL, 32'h0000_0010);
    wr(OFS_STATUS, 32'h0000_0000);
    for (int i = 0; i < 17; i++)
      peer_u.send(8'h40 + i[7:0], 1'b0, 1'b1);
    rdc(OFS_FIFO_LEVEL, 32'h0000_0010);
    rdc(OFS_STATUS, 32'h0000_0008);
    // Overrun stays visible in bit 11 until the error clear
    for (int i = 0; i < 16; i++)
      rdc(OFS_DATA, 32'h0000_0840 + i);
    wr(OFS_STATUS, 32'h0000_0000);
    rdc(OFS_STATUS, 32'h0000_0000);
    // Break: one zero character, the rest ignored until line idles
    peer_u.hold_line(1'b0);
    peer_u.send(8'h00, 1'b0, 1'b0);
    peer_u.send(8'h55, 1'b1, 1'b1);
    peer_u.hold_line(1'b1);
    peer_u.send(8'h3c, 1'b0, 1'b1);
    rdc(OFS_FIFO_LEVEL, 32'h0000_0002);
    rdc(OFS_DATA, 32'h0000_0400);
    rdc(OFS_STATUS, 32'h0000_0004);
    rdc(OFS_DATA, 32'h0000_003c);
    // Interrupt raised, cleared, then masked
    wr(OFS_RAW_INT, 32'h0000_001f);
    wr(OFS_INT_MASK, 32'h0000_0001);
    peer_u.send(8'h77, 1'b0, 1'b1);
    chk({31'h0, irq}, 32'h0000_0001);
    rdc(OFS_RAW_INT, 32'h0000_0001);
    wr(OFS_RAW_INT, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(OFS_INT_MASK, 32'h0000_0000);
    peer_u.send(8'h78, 1'b0, 1'b1);
    chk({31'h0, irq}, 32'h0000_0000);
    rdc(OFS_RAW_INT, 32'h0000_0001);
    // Unmapped place reads zero, write ignored
    wr(12'h020, 32'hffff_ffff);
    rdc(12'h020, 32'h0000_0000);
    chk({31'h0, hresp}, 32'h0000_0000);
    // Clock enable low: a character offered then is not taken
    @(posedge mclk);
    ce <= 1'b0;
    peer_u.send(8'h11, 1'b0, 1'b1);
    ce <= 1'b1;
    rdc(OFS_FIFO_LEVEL, 32'h0000_0002);
    end_of_test();
  end
endmodule
